// ---- verilog/incr_skip_or_defines.vh ----
// Purpose: shared constants for the increment / skip / or controller
// Assumes: 12-bit instruction words, 5-bit register field, 8-bit data
// Notes:   definitions only
`ifndef INCR_SKIP_OR_DEFINES_VH
`define INCR_SKIP_OR_DEFINES_VH

// instruction word fields
`define INSTR_W        12
`define OPC_HI         11
`define OPC_LO         6
`define DEST_BIT       5
`define FIELD_HI       4
`define FIELD_LO       0

// upper six bits of each handled instruction
`define OPC_INCREMENT  6'h0a
`define OPC_INC_SKIP   6'h0f
`define OPC_OR_ACCUM   6'h04

// the all-zero no-operation word
`define NOP_WORD       12'h000

// register field values
`define FIELD_INDIRECT 5'h00
`define SFR_LIMIT      5'h08

// alu operation codes
`define ALU_NONE       2'h0
`define ALU_INC        2'h1
`define ALU_OR         2'h2

// result width and zero value
`define RESULT_W       8
`define RESULT_ZERO    8'h00

// register port offsets
`define REG_CTRL       4'h0
`define REG_STATUS     4'h1
`define REG_INSTR      4'h2
`define REG_EXEC_CNT   4'h3
`define REG_SKIP_CNT   4'h4

// control register bits
`define CTRL_RUN_BIT   0
`define CTRL_CLR_CNT   1
`define CTRL_CLR_UNK   2
`define CTRL_RUN_RESET 1'b1

// status register bits
`define STAT_ZERO      0
`define STAT_SKIP_PEND 1
`define STAT_RUN       2
`define STAT_UNKNOWN   3
`define STAT_NOP_SEL   4
`define STAT_USED      5

`endif

// ---- verilog/op_decode.v ----
// Purpose: combinational decode of one instruction word into datapath controls
// Assumes: word is the word that the instruction latch is about to hold
// Notes:   any word outside the three handled kinds yields no controls
`timescale 1ns/1ps
`include "incr_skip_or_defines.vh"

module op_decode (
  input  wire [`INSTR_W-1:0]  word,
  output reg                  is_inc,
  output reg                  is_inc_skip,
  output reg                  is_or,
  output reg                  known,
  output reg  [1:0]           alu_op,
  output reg                  wr_w,
  output reg                  wr_f,
  output reg                  ld_z,
  output reg                  indirect,
  output reg                  sfr_sel,
  output reg  [4:0]           addr
);

  reg [5:0] opc;
  reg [4:0] field;
  reg       dest;

  always @* begin
    opc         = word[`OPC_HI:`OPC_LO];
    field       = word[`FIELD_HI:`FIELD_LO];
    dest        = word[`DEST_BIT];
    is_inc      = (opc == `OPC_INCREMENT);
    is_inc_skip = (opc == `OPC_INC_SKIP);
    is_or       = (opc == `OPC_OR_ACCUM);
    known       = is_inc | is_inc_skip | is_or;
    alu_op      = `ALU_NONE;
    wr_w        = 1'b0;
    wr_f        = 1'b0;
    ld_z        = 1'b0;
    indirect    = 1'b0;
    sfr_sel     = 1'b0;
    addr        = 5'h00;
    if (known) begin
      if (is_or) begin
        alu_op = `ALU_OR;
      end else begin
        alu_op = `ALU_INC;
      end
      wr_w     = ~dest;
      wr_f     = dest;
      ld_z     = is_inc | is_or;
      indirect = (field == `FIELD_INDIRECT);
      sfr_sel  = (field < `SFR_LIMIT);
      addr     = field;
    end
  end

endmodule

// ---- verilog/incr_skip_or_instr_control.v ----
// Purpose: single-cycle controller for increment, increment-and-skip and or
// Assumes: program store, alu and multiplexers sit on ref_clk; prog_data is the
//          word at the current program counter; alu_result is combinational
// Notes:   controls are issued from flip-flops for the whole execute cycle,
//          which stands in for the falling-edge setup; the datapath commits
//          on the rising edge that ends the cycle
//
// What this block does
// - decode 001010 as register increment
// - increment updates zero flag only
// - destination bit picks accumulator or file register
// - zero field means pointer-indirect address
// - operand from sfr data below 8
// - address mux picks indirect when field zero
// - target load asserted during execute cycle
// - zero load for increment and or
// - latch strobe and pc advance each running cycle
// - decode 001111 as increment-and-skip, no flags
// - zero result turns next word into nop
// - skip taken from alu zero, no load
// - skip leaves stored zero flag untouched
// - decode 000100 as or with accumulator
// - nop is all zero, no controls
`timescale 1ns/1ps
`include "incr_skip_or_defines.vh"

module incr_skip_or_instr_control #(
  parameter DATA_W = 16,
  parameter ADDR_W = 4
) (
  input  wire                  ref_clk,
  input  wire                  sys_rst,
  input  wire [`INSTR_W-1:0]   prog_data,
  input  wire [`RESULT_W-1:0]  alu_result,
  input  wire [ADDR_W-1:0]     reg_addr,
  input  wire [DATA_W-1:0]     reg_wdata,
  input  wire                  reg_wr,
  input  wire                  reg_rd,
  output reg  [DATA_W-1:0]     reg_rdata,
  output reg  [`INSTR_W-1:0]   instr_word,
  output reg                   instr_latch_strobe,
  output reg                   program_counter_advance,
  output reg                   nop_bus_sel,
  output reg                   alu_mux_sel,
  output reg                   reg_addr_mux_sel,
  output reg  [4:0]            direct_addr,
  output reg  [1:0]            alu_op,
  output reg                   load_w_reg,
  output reg                   load_f_reg,
  output reg                   load_z,
  output reg                   status_zero
);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  localparam [2:0] ST_BOOT = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_HALT = 3'b100;

  reg  [2:0]          state;
  reg  [2:0]          next_state;

  ////////////////////////////////////////////////////////////////////////////
  // internal state
  reg                 ctrl_run;
  reg                 exec_inc_skip;
  reg                 skip_pending;
  reg                 unknown_seen;
  reg  [DATA_W-1:0]   exec_cnt;
  reg  [DATA_W-1:0]   skip_cnt;

  wire                result_zero;
  wire                fetch_now;
  wire                skip_now;
  wire                skip_take;
  wire [`INSTR_W-1:0] next_instr;
  wire                ctrl_write;
  wire                clear_counts;
  wire                clear_unknown;

  wire                d_inc;
  wire                d_inc_skip;
  wire                d_or;
  wire                d_known;
  wire [1:0]          d_alu_op;
  wire                d_wr_w;
  wire                d_wr_f;
  wire                d_ld_z;
  wire                d_indirect;
  wire                d_sfr_sel;
  wire [4:0]          d_addr;

  reg  [DATA_W-1:0]   next_rdata;
  reg                 next_fetch;

  // next values of the execute controls
  reg                 next_alu_mux_sel;
  reg                 next_reg_addr_mux_sel;
  reg  [4:0]          next_direct_addr;
  reg  [1:0]          next_alu_op;
  reg                 next_load_w_reg;
  reg                 next_load_f_reg;
  reg                 next_load_z;
  reg                 next_exec_inc_skip;

  ////////////////////////////////////////////////////////////////////////////
  // zero indication and skip decision
  assign result_zero = (alu_result == `RESULT_ZERO);

  // the next word is latched on the edge that ends a cycle with this strobe high
  assign fetch_now   = program_counter_advance;

  // increment-and-skip ends with a zero result: next slot becomes a nop
  assign skip_now    = exec_inc_skip & result_zero;

  // a skip seen while fetching is held is kept until the next fetch
  assign skip_take   = fetch_now & (skip_now | skip_pending);

  assign next_instr  = fetch_now ? (skip_take ? `NOP_WORD : prog_data)
                                 : instr_word;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the word about to be latched
  op_decode u_decode (
    .word        (next_instr),
    .is_inc      (d_inc),
    .is_inc_skip (d_inc_skip),
    .is_or       (d_or),
    .known       (d_known),
    .alu_op      (d_alu_op),
    .wr_w        (d_wr_w),
    .wr_f        (d_wr_f),
    .ld_z        (d_ld_z),
    .indirect    (d_indirect),
    .sfr_sel     (d_sfr_sel),
    .addr        (d_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // run / halt sequencing
  always @* begin
    case (state)
      ST_BOOT: begin
        next_state = ctrl_run ? ST_RUN : ST_HALT;
      end
      ST_RUN: begin
        next_state = ctrl_run ? ST_RUN : ST_HALT;
      end
      ST_HALT: begin
        next_state = ctrl_run ? ST_RUN : ST_HALT;
      end
      default: begin
        next_state = ST_BOOT;
      end
    endcase
    next_fetch = (next_state == ST_RUN);
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_BOOT;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch overlap: latch and pc advance together every running cycle
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      instr_latch_strobe      <= 1'b0;
      program_counter_advance <= 1'b0;
    end else begin
      instr_latch_strobe      <= next_fetch;
      program_counter_advance <= next_fetch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction latch and the program mux select
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      instr_word  <= `NOP_WORD;
      nop_bus_sel <= 1'b0;
    end else begin
      instr_word <= next_instr;
      if (fetch_now) begin
        nop_bus_sel <= skip_take;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // controls for the word about to be latched; a held fetch issues nothing,
  // because the word in the latch has already run
  always @* begin
    next_alu_mux_sel      = 1'b0;
    next_reg_addr_mux_sel = 1'b0;
    next_direct_addr      = 5'h00;
    next_alu_op           = `ALU_NONE;
    next_load_w_reg       = 1'b0;
    next_load_f_reg       = 1'b0;
    next_load_z           = 1'b0;
    next_exec_inc_skip    = 1'b0;
    if (fetch_now) begin
      next_alu_mux_sel      = d_sfr_sel;
      next_reg_addr_mux_sel = d_indirect;
      next_direct_addr      = d_addr;
      next_alu_op           = d_alu_op;
      next_load_w_reg       = d_wr_w;
      next_load_f_reg       = d_wr_f;
      next_load_z           = d_ld_z;
      next_exec_inc_skip    = d_inc_skip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath controls for the execute cycle of the latched word
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      alu_mux_sel      <= 1'b0;
      reg_addr_mux_sel <= 1'b0;
      direct_addr      <= 5'h00;
      alu_op           <= `ALU_NONE;
      load_w_reg       <= 1'b0;
      load_f_reg       <= 1'b0;
      load_z           <= 1'b0;
      exec_inc_skip    <= 1'b0;
    end else begin
      alu_mux_sel      <= next_alu_mux_sel;
      reg_addr_mux_sel <= next_reg_addr_mux_sel;
      direct_addr      <= next_direct_addr;
      alu_op           <= next_alu_op;
      load_w_reg       <= next_load_w_reg;
      load_f_reg       <= next_load_f_reg;
      load_z           <= next_load_z;
      exec_inc_skip    <= next_exec_inc_skip;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored zero flag: only a zero load changes it
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      status_zero <= 1'b0;
    end else if (load_z) begin
      status_zero <= result_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // skip held over a halted fetch
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      skip_pending <= 1'b0;
    end else if (fetch_now) begin
      skip_pending <= 1'b0;
    end else if (skip_now) begin
      skip_pending <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  assign ctrl_write    = reg_wr & (reg_addr == `REG_CTRL);
  assign clear_counts  = ctrl_write & reg_wdata[`CTRL_CLR_CNT];
  assign clear_unknown = ctrl_write & reg_wdata[`CTRL_CLR_UNK];

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_run <= `CTRL_RUN_RESET;
    end else if (ctrl_write) begin
      ctrl_run <= reg_wdata[`CTRL_RUN_BIT];
    end
  end

  // a new unsupported word beats a clear in the same cycle
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      unknown_seen <= 1'b0;
    end else if (fetch_now & ~d_known & (next_instr != `NOP_WORD)) begin
      unknown_seen <= 1'b1;
    end else if (clear_unknown) begin
      unknown_seen <= 1'b0;
    end
  end

  // counters: a clear and a count in one cycle leave a count of one
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      exec_cnt <= {DATA_W{1'b0}};
      skip_cnt <= {DATA_W{1'b0}};
    end else begin
      if (fetch_now & d_known) begin
        exec_cnt <= (clear_counts ? {DATA_W{1'b0}} : exec_cnt)
                    + {{(DATA_W-1){1'b0}}, 1'b1};
      end else if (clear_counts) begin
        exec_cnt <= {DATA_W{1'b0}};
      end
      if (skip_take) begin
        skip_cnt <= (clear_counts ? {DATA_W{1'b0}} : skip_cnt)
                    + {{(DATA_W-1){1'b0}}, 1'b1};
      end else if (clear_counts) begin
        skip_cnt <= {DATA_W{1'b0}};
      end
    end
  end

  always @* begin
    next_rdata = {DATA_W{1'b0}};
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: begin
          next_rdata = {{(DATA_W-1){1'b0}}, ctrl_run};
        end
        `REG_STATUS: begin
          next_rdata = {{(DATA_W-`STAT_USED){1'b0}}, nop_bus_sel, unknown_seen,
                        (state == ST_RUN), skip_pending, status_zero};
        end
        `REG_INSTR: begin
          next_rdata = {{(DATA_W-`INSTR_W){1'b0}}, instr_word};
        end
        `REG_EXEC_CNT: begin
          next_rdata = exec_cnt;
        end
        `REG_SKIP_CNT: begin
          next_rdata = skip_cnt;
        end
        default: begin
          next_rdata = {DATA_W{1'b0}};
        end
      endcase
    end
  end

  // read data stand for exactly the cycle after the strobe
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= {DATA_W{1'b0}};
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ---- dv/incr_skip_or_monitor.sv ----
// Purpose: port assertions for the increment / skip / or controller
// Assumes: single clock, synchronous active-high reset
// Notes:   bound to every controller instance
`timescale 1ns/1ps
`include "incr_skip_or_defines.vh"

module incr_skip_or_monitor #(
  parameter DATA_W = 16,
  parameter ADDR_W = 4
) (
  input wire                ref_clk,
  input wire                sys_rst,
  input wire [11:0]         prog_data,
  input wire [7:0]          alu_result,
  input wire [ADDR_W-1:0]   reg_addr,
  input wire [DATA_W-1:0]   reg_wdata,
  input wire                reg_wr,
  input wire                reg_rd,
  input wire [DATA_W-1:0]   reg_rdata,
  input wire [11:0]         instr_word,
  input wire                instr_latch_strobe,
  input wire                program_counter_advance,
  input wire                nop_bus_sel,
  input wire                alu_mux_sel,
  input wire                reg_addr_mux_sel,
  input wire [4:0]          direct_addr,
  input wire [1:0]          alu_op,
  input wire                load_w_reg,
  input wire                load_f_reg,
  input wire                load_z,
  input wire                status_zero
);
  wire [5:0] opc = instr_word[11:6];
  wire [4:0] fld = instr_word[4:0];
  // controls are fresh only in a cycle whose opening edge fetched a word
  reg        run;
  always @(posedge ref_clk) run <= sys_rst ? 1'b0 : instr_latch_strobe;
  wire       inc = run && opc == `OPC_INCREMENT;
  wire       isk = run && opc == `OPC_INC_SKIP;
  wire       ior = run && opc == `OPC_OR_ACCUM;
  wire       hit = inc || isk || ior;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  chk_adv_pair: assert property (program_counter_advance == instr_latch_strobe)
    else $error("advance and latch strobe differ");
  chk_inc_ctrl: assert property (inc |-> alu_op == `ALU_INC && load_z)
    else $error("increment controls wrong");
  chk_skip_ctrl: assert property (isk |-> alu_op == `ALU_INC && !load_z)
    else $error("skip op controls wrong");
  chk_or_ctrl: assert property (ior |-> alu_op == `ALU_OR && load_z)
    else $error("or controls wrong");
  chk_dest_sel: assert property (hit |->
    load_f_reg == instr_word[5] && load_w_reg == !instr_word[5])
    else $error("destination load wrong");
  chk_opnd_sel: assert property (hit |-> alu_mux_sel == (fld < `SFR_LIMIT) && direct_addr == fld)
    else $error("operand select wrong");
  chk_addr_sel: assert property (hit |-> reg_addr_mux_sel == (fld == `FIELD_INDIRECT))
    else $error("address select wrong");
  chk_nop_quiet: assert property (run && instr_word == `NOP_WORD |->
    {alu_op, load_w_reg, load_f_reg, load_z, alu_mux_sel, reg_addr_mux_sel} == 7'h00)
    else $error("nop drives controls");
  chk_skip_take: assert property (isk && instr_latch_strobe &&
    alu_result == `RESULT_ZERO |=> nop_bus_sel && instr_word == `NOP_WORD)
    else $error("skip not taken");
  chk_skip_none: assert property (isk && alu_result != `RESULT_ZERO |=> !nop_bus_sel)
    else $error("spurious skip");
  chk_skip_keepz: assert property (isk |=> $stable(status_zero))
    else $error("skip changed zero flag");
  chk_zero_upd: assert property (run && load_z |=>
    status_zero == ($past(alu_result) == `RESULT_ZERO))
    else $error("zero flag update wrong");
  chk_nop_adv: assert property ($rose(nop_bus_sel) |-> run)
    else $error("pc held over skipped slot");

  cov_skip: cover property (isk && alu_result == `RESULT_ZERO);
  cov_indir: cover property (hit && fld == `FIELD_INDIRECT);
  cov_or_zero: cover property (ior && alu_result == `RESULT_ZERO);
endmodule

bind incr_skip_or_instr_control incr_skip_or_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mon (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .prog_data(prog_data), .alu_result(alu_result),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .instr_word(instr_word), .instr_latch_strobe(instr_latch_strobe),
  .program_counter_advance(program_counter_advance), .nop_bus_sel(nop_bus_sel),
  .alu_mux_sel(alu_mux_sel), .reg_addr_mux_sel(reg_addr_mux_sel),
  .direct_addr(direct_addr), .alu_op(alu_op), .load_w_reg(load_w_reg),
  .load_f_reg(load_f_reg), .load_z(load_z), .status_zero(status_zero));

// ---- dv/cpu_datapath_model.sv ----
// Purpose: program store, alu and register file facing the controller
// Assumes: controls valid for the whole execute cycle
// Notes:   field 0 reads entry 0, standing in for the pointer target
`timescale 1ns/1ps

module cpu_datapath_model (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        program_counter_advance,
  input  wire [1:0]  alu_op,
  input  wire [4:0]  direct_addr,
  input  wire        load_w_reg,
  input  wire        load_f_reg,
  output wire [11:0] prog_data,
  output wire [7:0]  alu_result
);
  logic [11:0] prog [0:31];
  logic [7:0]  fmem [0:31];
  logic [7:0]  w_reg;
  logic [4:0]  pc;
  logic        fetched;
  wire  [7:0]  opnd = fmem[direct_addr];

  assign prog_data = prog[pc];
  // idle alu shows zero so a skip from a wrong word would appear
  assign alu_result = (alu_op == 2'h1) ? opnd + 8'h01 :
                      (alu_op == 2'h2) ? (opnd | w_reg) : 8'h00;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pc <= 5'h00;
      fetched <= 1'b0;
    end else begin
      if (program_counter_advance) begin
        pc <= pc + 5'h01;
        fetched <= 1'b1;
      end
      if (load_f_reg)
        fmem[direct_addr] <= alu_result;
      if (load_w_reg)
        w_reg <= alu_result;
    end
  end
endmodule

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the instruction controller
// Assumes: datapath model supplies program words and alu results
// Notes:   expected slots are built from the program before each run
`timescale 1ns/1ps
`include "incr_skip_or_defines.vh"

module testbench;
  logic        ref_clk, sys_rst, reg_wr, reg_rd, z, skip, u;
  logic        rd_d = 1'b0;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  wire  [15:0] reg_rdata;
  wire  [11:0] prog_data, instr_word;
  wire  [7:0]  alu_result;
  wire  [4:0]  direct_addr;
  wire  [1:0]  alu_op;
  wire         instr_latch_strobe, program_counter_advance, nop_bus_sel, alu_mux_sel;
  wire         reg_addr_mux_sel, load_w_reg, load_f_reg, load_z, status_zero;
  logic [27:0] eq[$];
  logic [15:0] rq[$], mq[$];
  int          bad_count, checks_done, t, ne, ns;
  logic [7:0]  fm [0:31];
  logic [7:0]  w, r;

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  incr_skip_or_instr_control uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .prog_data(prog_data), .alu_result(alu_result),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_word(instr_word), .instr_latch_strobe(instr_latch_strobe),
    .program_counter_advance(program_counter_advance), .nop_bus_sel(nop_bus_sel),
    .alu_mux_sel(alu_mux_sel), .reg_addr_mux_sel(reg_addr_mux_sel),
    .direct_addr(direct_addr), .alu_op(alu_op), .load_w_reg(load_w_reg),
    .load_f_reg(load_f_reg), .load_z(load_z), .status_zero(status_zero));

  cpu_datapath_model dp (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .program_counter_advance(program_counter_advance),
    .alu_op(alu_op), .direct_addr(direct_addr), .load_w_reg(load_w_reg),
    .load_f_reg(load_f_reg), .prog_data(prog_data), .alu_result(alu_result));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [27:0] g, input logic [27:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge ref_clk) rd_d <= reg_rd;

  always @(negedge ref_clk) begin
    if (dp.fetched === 1'b1 && eq.size() > 0)
      check({instr_word, nop_bus_sel, alu_mux_sel, reg_addr_mux_sel, direct_addr, alu_op,
             load_w_reg, load_f_reg, load_z, status_zero, instr_latch_strobe,
             program_counter_advance}, eq.pop_front());
    if (rd_d)
      check(reg_rdata & mq.pop_front(), rq.pop_front());
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    rq.push_back(e);
    mq.push_back(m);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  // random program and data, with a directed skip at its head
  task automatic load();
    logic [5:0] ops [4];
    ops = '{`OPC_INCREMENT, `OPC_INC_SKIP, `OPC_OR_ACCUM, 6'h00};
    for (int i = 0; i < 32; i++) begin
      dp.prog[i] = (i < 28) ? {ops[$urandom % 4], 6'($urandom)} : `NOP_WORD;
      dp.fmem[i] = ($urandom % 3 == 0) ? 8'hff : 8'($urandom);
    end
    dp.w_reg = 8'($urandom);
    dp.fmem[3] = 8'hff;
    dp.prog[0] = 12'h3c3;
    dp.prog[2] = 12'h3c3;
  endtask

  task automatic build();
    logic [11:0] wd;
    logic [5:0]  op;
    logic [4:0]  f;
    logic        kn;
    z = 1'b0;
    skip = 1'b0;
    ne = 0;
    ns = 0;
    u = 1'b0;
    w = dp.w_reg;
    for (int i = 0; i < 32; i++)
      fm[i] = dp.fmem[i];
    for (int p = 0; p < 28; p++) begin
      wd = skip ? `NOP_WORD : dp.prog[p];
      op = wd[11:6];
      f = wd[4:0];
      kn = op == `OPC_INCREMENT || op == `OPC_INC_SKIP || op == `OPC_OR_ACCUM;
      ne += kn;
      u = u | (!kn && wd != `NOP_WORD);
      r = (op == `OPC_OR_ACCUM) ? (fm[f] | w) : fm[f] + 8'h01;
      eq.push_back({wd, skip, kn && f < `SFR_LIMIT, kn && f == `FIELD_INDIRECT,
                    kn ? f : 5'h00, kn ? ((op == `OPC_OR_ACCUM) ? `ALU_OR : `ALU_INC) : `ALU_NONE,
                    kn && !wd[5], kn && wd[5], kn && op != `OPC_INC_SKIP, z, 2'b11});
      skip = op == `OPC_INC_SKIP && r == `RESULT_ZERO;
      ns += skip;
      if (kn && wd[5])
        fm[f] = r;
      if (kn && !wd[5])
        w = r;
      if (kn && op != `OPC_INC_SKIP)
        z = r == `RESULT_ZERO;
    end
  endtask

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    sys_rst = 1'b1;
    void'($urandom(30));
    for (int k = 0; k < 2; k++) begin
      sys_rst <= 1'b1;
      repeat (20) @(posedge ref_clk);
      load();
      build();
      sys_rst <= 1'b0;
      rd(`REG_CTRL, 16'h0001, 16'hffff);
      for (t = 0; t < 200 && eq.size() > 0; t++)
        @(posedge ref_clk);
      if (eq.size() > 0) begin
        bad_count++;
        tally_and_finish();
      end
      wr(`REG_CTRL, 16'h0000);
      rd(`REG_EXEC_CNT, 16'(ne), 16'hffff);
      rd(`REG_SKIP_CNT, 16'(ns), 16'hffff);
      rd(`REG_STATUS, {11'h000, 1'b0, u, 2'b00, z}, 16'h001f);
      wr(`REG_CTRL, 16'h0006);
      rd(`REG_EXEC_CNT, 16'h0000, 16'hffff);
      rd(`REG_SKIP_CNT, 16'h0000, 16'hffff);
      wr(4'hf, 16'hffff);
      rd(4'hf, 16'h0000, 16'hffff);
      rd(`REG_INSTR, 16'h0000, 16'h0fff);
      rd(`REG_STATUS, {15'h0000, z}, 16'h000f);
      repeat (3) @(posedge ref_clk);
    end
    tally_and_finish();
  end
endmodule
